//--- port_pad_control_and_reg_base_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin \
  n_fail++; $display("Error %s expected %h seen %h", nm, ex, gt); end end

module port_pad_control_and_reg_base_bench;
  import ppc_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire hready;
  logic [31:0] hrdata;
  logic hresp;
  // One pin pattern feeds every input group
  logic [7:0] pins = 8'h00;
  logic [3:0] pen = 4'h0;
  logic [3:0] pout = 4'h0;
  logic [7:0] tcl = 8'h00;
  logic [7:0] sen = 8'h00;
  logic [7:0] ao, ae, bo, be, eo, ee, to, te, so, se, pu, wd;
  logic [3:0] mo, me;
  logic [7:0] m;
  logic [31:0] q;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  // Register tables for reset and masked write checks
  logic [9:0] ri [6] = '{IDX_PULLUP, IDX_DRIVE, IDX_PORT_A_DIR,
    IDX_PORT_E_DIR, IDX_RAM_BASE, IDX_PORT_B_DIR};
  logic [7:0] rr [6] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] rm [6] = '{8'hF3, 8'hF3, 8'hFF, 8'hFC, 8'hE0, 8'hFF};

  ppc_top uut (.mclk(mclk), .rst(rst), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .port_a_in(pins), .port_a_out(ao), .port_a_oe(ae), .port_b_in(pins),
    .port_b_out(bo), .port_b_oe(be), .port_e_in(pins), .port_e_out(eo),
    .port_e_oe(ee), .modulator_shared_pins_in(pins[3:0]),
    .modulator_shared_pins_out(mo), .modulator_shared_pins_oe(me),
    .timer_shared_pins_in(pins), .timer_shared_pins_out(to),
    .timer_shared_pins_oe(te), .serial_shared_pins_in(pins),
    .serial_shared_pins_out(so), .serial_shared_pins_oe(se),
    .pwm_chan_en(pen), .pwm_chan_out(pout), .timer_claim(tcl),
    .timer_func_out(pins), .timer_func_oe(~pins), .serial_func_en(sen),
    .serial_func_out(~pins), .serial_func_oe(pins), .pullup_enable(pu),
    .weak_drive(wd));

  // Clock at 4 ns
  initial begin
    forever #2 mclk = ~mclk;
  end

  // Byte address of a register in window b, half h
  function automatic logic [31:0] ad(input logic [4:0] b, input logic h,
                                     input logic [9:0] i);
    ad = {14'h0, b, h, i, 2'b00};
  endfunction

  // One AHB-Lite single transfer, waits on hready in both phases
  task automatic xf(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge mclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge mclk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  // Read and compare the low byte, upper bits must be zero
  task automatic rc(input logic [31:0] a, input logic [7:0] e);
    xf(1'b0, a, 8'h00);
    `CHK("rdata", {24'h0, e}, q)
    `CHK("hresp", 1'b0, hresp)
  endtask

  // Let pad and mux outputs settle, sample away from the edge
  task automatic settle();
    repeat (5) @(posedge mclk);
    @(negedge mclk);
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    settle();
    `CHK("pull pads", 8'h10, pu)
    `CHK("drive pads", 8'h00, wd)
    `CHK("dir pads", 8'h00, ae | be | ee | te | se)
    rc(ad(5'h00, 1'b0, IDX_BLOCK_BASE), 8'h00);
    // Reset values, then all-ones writes through the masks
    for (int k = 0; k < 6; k++) begin
      rc(ad(5'h00, 1'b0, ri[k]), rr[k]);
      xf(1'b1, ad(5'h00, 1'b0, ri[k]), 8'hFF);
      rc(ad(5'h00, 1'b0, ri[k]), rm[k]);
    end
    settle();
    `CHK("pull pads", 8'hF3, pu)
    `CHK("drive pads", 8'hF3, wd)
    // Mixed direction: outputs read the latch, inputs the pin
    @(posedge mclk);
    pins <= 8'hA5;
    xf(1'b1, ad(5'h00, 1'b0, IDX_PORT_A_DIR), 8'h0F);
    xf(1'b1, ad(5'h00, 1'b0, IDX_PORT_A_DATA), 8'h5A);
    xf(1'b1, ad(5'h00, 1'b0, IDX_PORT_B_DATA), 8'h3C);
    xf(1'b1, ad(5'h00, 1'b0, IDX_PORT_E_DATA), 8'hC3);
    settle();
    rc(ad(5'h00, 1'b0, IDX_PORT_A_DATA), 8'hAA);
    `CHK("port a oe", 8'h0F, ae)
    `CHK("port a out", 8'h5A, ao)
    `CHK("port b out", 8'h3C, bo)
    `CHK("port e out", 8'hC3, eo)
    // Move the block to the top window and back
    xf(1'b1, ad(5'h00, 1'b0, IDX_BLOCK_BASE), 8'hFF);
    rc(ad(5'h1F, 1'b0, IDX_BLOCK_BASE), 8'hF9);
    rc(ad(5'h1F, 1'b0, IDX_PULLUP), 8'hF3);
    rc(ad(5'h00, 1'b0, IDX_PULLUP), 8'h00);
    rc(ad(5'h1F, 1'b1, IDX_PULLUP), 8'h00);
    xf(1'b1, ad(5'h1F, 1'b0, IDX_BLOCK_BASE), 8'h00);
    rc(ad(5'h00, 1'b0, IDX_PULLUP), 8'hF3);
    // Shared pins as GPIO, then partly claimed by peripherals
    xf(1'b1, ad(5'h00, 1'b0, IDX_MOD_DIR), 8'h0C);
    xf(1'b1, ad(5'h00, 1'b0, IDX_MOD_DATA), 8'h03);
    xf(1'b1, ad(5'h00, 1'b0, IDX_TIM_DIR), 8'h0F);
    xf(1'b1, ad(5'h00, 1'b0, IDX_TIM_DATA), 8'h55);
    xf(1'b1, ad(5'h00, 1'b0, IDX_SER_DIR), 8'hF0);
    xf(1'b1, ad(5'h00, 1'b0, IDX_SER_DATA), 8'h33);
    for (int k = 0; k < 2; k++) begin
      m = k ? 8'hFF : 8'h00;
      @(posedge mclk);
      pen <= m[3:0] & 4'h5;
      pout <= 4'hA;
      tcl <= m & 8'hF0;
      sen <= m & 8'h0F;
      settle();
      `CHK("mod out", (4'hA & pen) | (4'h3 & ~pen), mo)
      `CHK("mod oe", pen | 4'hC, me)
      `CHK("tim out", (pins & tcl) | (8'h55 & ~tcl), to)
      `CHK("tim oe", (~pins & tcl) | (8'h0F & ~tcl), te)
      `CHK("ser out", (~pins & sen) | (8'h33 & ~sen), so)
      `CHK("ser oe", (pins & sen) | (8'hF0 & ~sen), se)
    end
    summarize();
  end
endmodule

`default_nettype wire

//--- ppc_mux_if.sv
`timescale 1ns/1ps
`default_nettype none

// Latches and directions of the shared pin groups, register file to mux
interface ppc_mux_if;
  logic [7:0] mod_data;
  logic [7:0] mod_dir;
  logic [7:0] tim_data;
  logic [7:0] tim_dir;
  logic [7:0] ser_data;
  logic [7:0] ser_dir;

  // Register file drives, pin mux consumes
  modport regs (output mod_data, mod_dir, tim_data, tim_dir, ser_data,
                ser_dir);
  modport mux (input mod_data, mod_dir, tim_data, tim_dir, ser_data,
               ser_dir);
endinterface

`default_nettype wire

//--- ppc_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none

// Hands each shared pin to its peripheral or to general-purpose I/O
module ppc_pin_mux
  import ppc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  ppc_mux_if.mux cfg,
  input wire logic [MOD_W-1:0] pwm_chan_en,
  input wire logic [MOD_W-1:0] pwm_chan_out,
  input wire logic [PORT_W-1:0] timer_claim,
  input wire logic [PORT_W-1:0] timer_func_out,
  input wire logic [PORT_W-1:0] timer_func_oe,
  input wire logic [PORT_W-1:0] serial_func_en,
  input wire logic [PORT_W-1:0] serial_func_out,
  input wire logic [PORT_W-1:0] serial_func_oe,
  output logic [MOD_W-1:0] modulator_shared_pins_out,
  output logic [MOD_W-1:0] modulator_shared_pins_oe,
  output logic [PORT_W-1:0] timer_shared_pins_out,
  output logic [PORT_W-1:0] timer_shared_pins_oe,
  output logic [PORT_W-1:0] serial_shared_pins_out,
  output logic [PORT_W-1:0] serial_shared_pins_oe
);

  // Per bit: peripheral value where claimed, else the given fallback
  function automatic logic [7:0] pick(input logic [7:0] en,
                                      input logic [7:0] func,
                                      input logic [7:0] gpio);
    pick = (en & func) | (~en & gpio);
  endfunction

  // Modulator picks over the full byte; only the low lanes reach pins
  logic [7:0] mod_out_nxt; // Next modulator pin levels
  logic [7:0] mod_oe_nxt; // Next modulator pin enables
  assign mod_out_nxt = pick({4'h0, pwm_chan_en}, {4'h0, pwm_chan_out},
                            cfg.mod_data);
  assign mod_oe_nxt = pick({4'h0, pwm_chan_en}, 8'hFF, cfg.mod_dir);

  // Modulator pins: an enabled channel always drives its pin
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      modulator_shared_pins_out <= '0;
      modulator_shared_pins_oe <= '0;
    end else begin
      modulator_shared_pins_out <= mod_out_nxt[MOD_W-1:0];
      modulator_shared_pins_oe <= mod_oe_nxt[MOD_W-1:0];
    end
  end

  // Timer pins: capture/compare or accumulator claim wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      timer_shared_pins_out <= '0;
      timer_shared_pins_oe <= '0;
    end else begin
      timer_shared_pins_out <= pick(timer_claim, timer_func_out,
        cfg.tim_data);
      timer_shared_pins_oe <= pick(timer_claim, timer_func_oe,
        cfg.tim_dir);
    end
  end

  // Serial pins: enabled serial interfaces take their pins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      serial_shared_pins_out <= '0;
      serial_shared_pins_oe <= '0;
    end else begin
      serial_shared_pins_out <= pick(serial_func_en, serial_func_out,
        cfg.ser_data);
      serial_shared_pins_oe <= pick(serial_func_en, serial_func_oe,
        cfg.ser_dir);
    end
  end

endmodule

`default_nettype wire

//--- ppc_pkg.sv
`default_nettype none

package ppc_pkg;

  // Register indices in the 16-bit internal register space
  localparam logic [9:0] IDX_PORT_A_DATA = 10'h000;
  localparam logic [9:0] IDX_PORT_B_DATA = 10'h001;
  localparam logic [9:0] IDX_PORT_A_DIR = 10'h002;
  localparam logic [9:0] IDX_PORT_B_DIR = 10'h003;
  localparam logic [9:0] IDX_PORT_E_DATA = 10'h008;
  localparam logic [9:0] IDX_PORT_E_DIR = 10'h009;
  localparam logic [9:0] IDX_PIN_ASSIGN = 10'h00A;
  localparam logic [9:0] IDX_MODE_SEL = 10'h00B;
  localparam logic [9:0] IDX_PULLUP = 10'h00C;
  localparam logic [9:0] IDX_DRIVE = 10'h00D;
  localparam logic [9:0] IDX_RAM_BASE = 10'h010;
  localparam logic [9:0] IDX_BLOCK_BASE = 10'h011;
  localparam logic [9:0] IDX_MOD_DATA = 10'h056;
  localparam logic [9:0] IDX_MOD_DIR = 10'h057;
  localparam logic [9:0] IDX_TIM_DATA = 10'h0AE;
  localparam logic [9:0] IDX_TIM_DIR = 10'h0AF;
  localparam logic [9:0] IDX_SER_DATA = 10'h0D6;
  localparam logic [9:0] IDX_SER_DIR = 10'h0D7;

  // Bus address to register index: byte address = 4 * index
  localparam int AHB_IDX_LSB = 2;
  localparam int AHB_IDX_MSB = 17;
  // Base field position inside the 16-bit index and in its register
  localparam int BASE_MSB = 15;
  localparam int BASE_LSB = 11;
  localparam int HALF_BIT = 10;
  localparam int BASE_FIELD_LSB = 3;

  // Implemented bits of the mixed-access registers
  localparam logic [7:0] PULLUP_MASK = 8'hF3;
  localparam logic [7:0] DRIVE_MASK = 8'hF3;
  localparam logic [7:0] PORT_E_DIR_MASK = 8'hFC;
  localparam logic [7:0] RAM_BASE_MASK = 8'hE0;
  localparam logic [7:0] BLOCK_BASE_MASK = 8'hF9;

  // Reset values
  localparam logic [7:0] PULLUP_RST = 8'h10;
  localparam logic [7:0] DRIVE_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] BLOCK_BASE_RST = 8'h00;
  localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

  // Pin group widths and the packed input vector layout
  localparam int PORT_W = 8;
  localparam int MOD_W = 4;
  localparam int PIN_W = 5 * PORT_W + MOD_W;

  // Read value of a port: output bits read the latch, inputs the pin
  function automatic logic [7:0] ppc_port_read(input logic [7:0] data,
                                               input logic [7:0] dir,
                                               input logic [7:0] pin);
    ppc_port_read = (data & dir) | (pin & ~dir);
  endfunction

endpackage

`default_nettype wire

//--- ppc_top.sv
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Pull-up enables per port, port E on
// - Reduced-drive bit per port, full drive at reset
// - Five-bit base field relocates block on 2K
// - Base field matches upper five address bits
// - Only lower 1K of window holds registers
// - After reset block sits at base zero
// - Modulator pins GPIO unless modulator enabled
// - Timer pins GPIO unless timer claims them
// - Serial pins GPIO unless serial interfaces enabled
// - Direction bit set means output, reset clears
module ppc_top
  import ppc_pkg::*;
#(
  parameter logic [7:0] PIN_ASSIGN_RST = 8'h00,
  parameter logic [7:0] MODE_SEL_RST = 8'h00,
  parameter logic [7:0] RAM_BASE_RST = 8'h00
) (
  input wire logic mclk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // General-purpose ports A, B and E
  input wire logic [ppc_pkg::PORT_W-1:0] port_a_in,
  output logic [ppc_pkg::PORT_W-1:0] port_a_out,
  output logic [ppc_pkg::PORT_W-1:0] port_a_oe,
  input wire logic [ppc_pkg::PORT_W-1:0] port_b_in,
  output logic [ppc_pkg::PORT_W-1:0] port_b_out,
  output logic [ppc_pkg::PORT_W-1:0] port_b_oe,
  input wire logic [ppc_pkg::PORT_W-1:0] port_e_in,
  output logic [ppc_pkg::PORT_W-1:0] port_e_out,
  output logic [ppc_pkg::PORT_W-1:0] port_e_oe,
  // Shared pin groups
  input wire logic [ppc_pkg::MOD_W-1:0] modulator_shared_pins_in,
  output logic [ppc_pkg::MOD_W-1:0] modulator_shared_pins_out,
  output logic [ppc_pkg::MOD_W-1:0] modulator_shared_pins_oe,
  input wire logic [ppc_pkg::PORT_W-1:0] timer_shared_pins_in,
  output logic [ppc_pkg::PORT_W-1:0] timer_shared_pins_out,
  output logic [ppc_pkg::PORT_W-1:0] timer_shared_pins_oe,
  input wire logic [ppc_pkg::PORT_W-1:0] serial_shared_pins_in,
  output logic [ppc_pkg::PORT_W-1:0] serial_shared_pins_out,
  output logic [ppc_pkg::PORT_W-1:0] serial_shared_pins_oe,
  // Peripheral requests for the shared pins
  input wire logic [ppc_pkg::MOD_W-1:0] pwm_chan_en,
  input wire logic [ppc_pkg::MOD_W-1:0] pwm_chan_out,
  input wire logic [ppc_pkg::PORT_W-1:0] timer_claim,
  input wire logic [ppc_pkg::PORT_W-1:0] timer_func_out,
  input wire logic [ppc_pkg::PORT_W-1:0] timer_func_oe,
  input wire logic [ppc_pkg::PORT_W-1:0] serial_func_en,
  input wire logic [ppc_pkg::PORT_W-1:0] serial_func_out,
  input wire logic [ppc_pkg::PORT_W-1:0] serial_func_oe,
  // Pad controls
  output logic [7:0] pullup_enable,
  output logic [7:0] weak_drive
);

  import ppc_pkg::*;

  // Register storage
  logic [7:0] port_b_data_r;
  logic [7:0] port_e_data_r;
  logic [7:0] port_a_data_r;
  logic [7:0] port_a_dir_r;
  logic [7:0] port_b_dir_r;
  logic [7:0] port_e_dir_r;
  logic [7:0] pin_assign_r;
  logic [7:0] mode_sel_r;
  logic [7:0] pullup_r;
  logic [7:0] drive_r;
  logic [7:0] ram_base_r;
  logic [7:0] block_base_r;
  logic [7:0] mod_data_r;
  logic [7:0] mod_dir_r;
  logic [7:0] tim_data_r;
  logic [7:0] tim_dir_r;
  logic [7:0] ser_data_r;
  logic [7:0] ser_dir_r;

  // Bus pipeline state
  logic wr_pend_r; // Write data phase pending
  logic [9:0] wr_idx_r; // Index of the pending write
  logic [7:0] wdata; // Low byte of the write data
  logic [15:0] req_idx; // Index of the offered address phase
  logic req_take; // Address phase taken this edge
  logic req_hit; // Address phase lands on the block

  // Input synchronisers
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s1_r;
  logic [PIN_W-1:0] pin_s2_r;
  logic [PIN_W-1:0] pin_s3_r;
  logic [PIN_W-1:0] pin_r; // Settled pin levels
  logic [7:0] pa_pin;
  logic [7:0] pb_pin;
  logic [7:0] pe_pin;
  logic [7:0] pp_pin;
  logic [7:0] pt_pin;
  logic [7:0] ps_pin;

  // Carrier to the pin mux
  ppc_mux_if mux_cfg ();

  assign wdata = hwdata[7:0];
  assign req_idx = haddr[AHB_IDX_MSB:AHB_IDX_LSB];
  assign req_take = hsel && htrans[1] && hready;
  // Match the base field on the upper bits, lower half only
  assign req_hit = (req_idx[BASE_MSB:BASE_LSB] ==
                    block_base_r[7:BASE_FIELD_LSB])
                   && !req_idx[HALF_BIT];

  // Write strobe for one register index
  function automatic logic wr_to(input logic [9:0] idx);
    wr_to = wr_pend_r && (wr_idx_r == idx);
  endfunction

  // Capture the address phase; writes complete in the data phase
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= '0;
    end else begin
      wr_pend_r <= req_take && hwrite && req_hit;
      wr_idx_r <= req_idx[9:0];
    end
  end

  // Zero-wait slave, always OKAY
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Three-stage synchroniser; a one counts once stages two and three agree, and the bit clears while they differ
  assign pin_raw = {serial_shared_pins_in, timer_shared_pins_in,
                    modulator_shared_pins_in, port_e_in, port_b_in,
                    port_a_in};
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      pin_r <= '0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_r <= (pin_r & ~(pin_s2_r ^ pin_s3_r)) |
               (pin_s3_r & ~(pin_s2_r ^ pin_s3_r));
    end
  end
  assign pa_pin = pin_r[PORT_W-1:0];
  assign pb_pin = pin_r[2*PORT_W-1:PORT_W];
  assign pe_pin = pin_r[3*PORT_W-1:2*PORT_W];
  assign pp_pin = {4'h0, pin_r[3*PORT_W+MOD_W-1:3*PORT_W]};
  assign pt_pin = pin_r[4*PORT_W+MOD_W-1:3*PORT_W+MOD_W];
  assign ps_pin = pin_r[PIN_W-1:4*PORT_W+MOD_W];

  // Read multiplexer; unmapped indices read zero
  function automatic logic [7:0] rd_byte(input logic [9:0] idx);
    case (idx)
      IDX_PORT_A_DATA: rd_byte = ppc_port_read(port_a_data_r,
                                               port_a_dir_r, pa_pin);
      IDX_PORT_B_DATA: rd_byte = ppc_port_read(port_b_data_r,
                                               port_b_dir_r, pb_pin);
      IDX_PORT_A_DIR: rd_byte = port_a_dir_r;
      IDX_PORT_B_DIR: rd_byte = port_b_dir_r;
      IDX_PORT_E_DATA: rd_byte = ppc_port_read(port_e_data_r,
                                               port_e_dir_r, pe_pin);
      IDX_PORT_E_DIR: rd_byte = port_e_dir_r;
      IDX_PIN_ASSIGN: rd_byte = pin_assign_r;
      IDX_MODE_SEL: rd_byte = mode_sel_r;
      IDX_PULLUP: rd_byte = pullup_r;
      IDX_DRIVE: rd_byte = drive_r;
      IDX_RAM_BASE: rd_byte = ram_base_r;
      IDX_BLOCK_BASE: rd_byte = block_base_r;
      IDX_MOD_DATA: rd_byte = ppc_port_read(mod_data_r, mod_dir_r,
                                            pp_pin);
      IDX_MOD_DIR: rd_byte = mod_dir_r;
      IDX_TIM_DATA: rd_byte = ppc_port_read(tim_data_r, tim_dir_r,
                                            pt_pin);
      IDX_TIM_DIR: rd_byte = tim_dir_r;
      IDX_SER_DATA: rd_byte = ppc_port_read(ser_data_r, ser_dir_r,
                                            ps_pin);
      IDX_SER_DIR: rd_byte = ser_dir_r;
      default: rd_byte = 8'h00;
    endcase
  endfunction

  // Read data is sampled at the address phase and held for the data phase
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hrdata <= RDATA_NONE;
    end else if (req_take && !hwrite) begin
      if (req_hit) begin
        hrdata <= {24'h00_0000, rd_byte(req_idx[9:0])};
      end else begin
        hrdata <= RDATA_NONE;
      end
    end
  end

  // Port A and B latches and directions
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      port_a_data_r <= DATA_RST;
      port_b_data_r <= DATA_RST;
      port_a_dir_r <= DIR_RST;
      port_b_dir_r <= DIR_RST;
    end else begin
      if (wr_to(IDX_PORT_A_DATA)) begin
        port_a_data_r <= wdata;
      end
      if (wr_to(IDX_PORT_B_DATA)) begin
        port_b_data_r <= wdata;
      end
      if (wr_to(IDX_PORT_A_DIR)) begin
        port_a_dir_r <= wdata;
      end
      if (wr_to(IDX_PORT_B_DIR)) begin
        port_b_dir_r <= wdata;
      end
    end
  end

  // Port E: bits one and zero are input only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      port_e_data_r <= DATA_RST;
      port_e_dir_r <= DIR_RST;
    end else begin
      if (wr_to(IDX_PORT_E_DATA)) begin
        port_e_data_r <= wdata;
      end
      if (wr_to(IDX_PORT_E_DIR)) begin
        port_e_dir_r <= wdata & PORT_E_DIR_MASK;
      end
    end
  end

  // Pin assignment and mode select are stored for the bus side
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_assign_r <= PIN_ASSIGN_RST;
      mode_sel_r <= MODE_SEL_RST;
    end else begin
      if (wr_to(IDX_PIN_ASSIGN)) begin
        pin_assign_r <= wdata;
      end
      if (wr_to(IDX_MODE_SEL)) begin
        mode_sel_r <= wdata;
      end
    end
  end

  // Pull-up enables; port E starts enabled
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pullup_r <= PULLUP_RST;
    end else if (wr_to(IDX_PULLUP)) begin
      pullup_r <= wdata & PULLUP_MASK;
    end
  end

  // Reduced-drive bits; every port starts at full drive
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      drive_r <= DRIVE_RST;
    end else if (wr_to(IDX_DRIVE)) begin
      drive_r <= wdata & DRIVE_MASK;
    end
  end

  // RAM and register block base fields
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ram_base_r <= RAM_BASE_RST & RAM_BASE_MASK;
      block_base_r <= BLOCK_BASE_RST;
    end else begin
      if (wr_to(IDX_RAM_BASE)) begin
        ram_base_r <= wdata & RAM_BASE_MASK;
      end
      if (wr_to(IDX_BLOCK_BASE)) begin
        block_base_r <= wdata & BLOCK_BASE_MASK;
      end
    end
  end

  // Shared pin groups: latches and directions
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mod_data_r <= DATA_RST;
      tim_data_r <= DATA_RST;
      ser_data_r <= DATA_RST;
      mod_dir_r <= DIR_RST;
      tim_dir_r <= DIR_RST;
      ser_dir_r <= DIR_RST;
    end else begin
      if (wr_to(IDX_MOD_DATA)) begin
        mod_data_r <= wdata;
      end
      if (wr_to(IDX_MOD_DIR)) begin
        mod_dir_r <= wdata;
      end
      if (wr_to(IDX_TIM_DATA)) begin
        tim_data_r <= wdata;
      end
      if (wr_to(IDX_TIM_DIR)) begin
        tim_dir_r <= wdata;
      end
      if (wr_to(IDX_SER_DATA)) begin
        ser_data_r <= wdata;
      end
      if (wr_to(IDX_SER_DIR)) begin
        ser_dir_r <= wdata;
      end
    end
  end

  // Pad drivers for the plain ports follow latches and directions
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      port_a_out <= '0;
      port_b_out <= '0;
      port_e_out <= '0;
      port_a_oe <= '0;
      port_b_oe <= '0;
      port_e_oe <= '0;
    end else begin
      port_a_out <= port_a_data_r;
      port_b_out <= port_b_data_r;
      port_e_out <= port_e_data_r;
      port_a_oe <= port_a_dir_r;
      port_b_oe <= port_b_dir_r;
      port_e_oe <= port_e_dir_r;
    end
  end

  // Pad control outputs, one cycle behind the registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pullup_enable <= PULLUP_RST;
      weak_drive <= DRIVE_RST;
    end else begin
      pullup_enable <= pullup_r;
      weak_drive <= drive_r;
    end
  end

  assign mux_cfg.mod_data = mod_data_r;
  assign mux_cfg.mod_dir = mod_dir_r;
  assign mux_cfg.tim_data = tim_data_r;
  assign mux_cfg.tim_dir = tim_dir_r;
  assign mux_cfg.ser_data = ser_data_r;
  assign mux_cfg.ser_dir = ser_dir_r;

  // Shared pin ownership
  ppc_pin_mux u_mux (
    .mclk(mclk),
    .rst(rst),
    .cfg(mux_cfg),
    .pwm_chan_en(pwm_chan_en),
    .pwm_chan_out(pwm_chan_out),
    .timer_claim(timer_claim),
    .timer_func_out(timer_func_out),
    .timer_func_oe(timer_func_oe),
    .serial_func_en(serial_func_en),
    .serial_func_out(serial_func_out),
    .serial_func_oe(serial_func_oe),
    .modulator_shared_pins_out(modulator_shared_pins_out),
    .modulator_shared_pins_oe(modulator_shared_pins_oe),
    .timer_shared_pins_out(timer_shared_pins_out),
    .timer_shared_pins_oe(timer_shared_pins_oe),
    .serial_shared_pins_out(serial_shared_pins_out),
    .serial_shared_pins_oe(serial_shared_pins_oe)
  );

endmodule

`default_nettype wire

//--- ppc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// Port-level checker for the pad and pin-sharing block
module ppc_top_asserts
  import ppc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [7:0] port_a_oe,
  input wire logic [7:0] port_b_oe,
  input wire logic [7:0] port_e_oe,
  input wire logic [3:0] modulator_shared_pins_out,
  input wire logic [3:0] modulator_shared_pins_oe,
  input wire logic [7:0] timer_shared_pins_out,
  input wire logic [7:0] timer_shared_pins_oe,
  input wire logic [7:0] serial_shared_pins_out,
  input wire logic [7:0] serial_shared_pins_oe,
  input wire logic [3:0] pwm_chan_en,
  input wire logic [3:0] pwm_chan_out,
  input wire logic [7:0] timer_claim,
  input wire logic [7:0] timer_func_out,
  input wire logic [7:0] timer_func_oe,
  input wire logic [7:0] serial_func_en,
  input wire logic [7:0] serial_func_out,
  input wire logic [7:0] serial_func_oe,
  input wire logic [7:0] pullup_enable,
  input wire logic [7:0] weak_drive
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Read taken in the upper half of the window
  logic up_rd;
  assign up_rd = hsel && htrans[1] && hready && !hwrite && haddr[12];

  AST_PULL_RST: assert property ($fell(rst) |-> pullup_enable == 8'h10)
    else $error("pull-up pads not at reset state");
  AST_DRV_RST: assert property ($fell(rst) |-> weak_drive == 8'h00)
    else $error("drive pads not at full drive after reset");
  AST_DIR_RST: assert property ($fell(rst) |-> (port_a_oe | port_b_oe
    | port_e_oe | timer_shared_pins_oe | serial_shared_pins_oe) == 8'h00)
    else $error("pin driving right after reset");
  AST_PAD_ZERO: assert property ((pullup_enable[3:2] | weak_drive[3:2])
    == 2'h0) else $error("constant-zero pad bits set");
  AST_UPPER: assert property (up_rd |=> hrdata == 32'h0)
    else $error("upper half of window answered");
  AST_MOD: assert property (pwm_chan_en != 4'h0 |=>
    (((modulator_shared_pins_out ^ $past(pwm_chan_out))
    | ~modulator_shared_pins_oe) & $past(pwm_chan_en)) == 4'h0)
    else $error("modulator does not own its pins");
  AST_TIM: assert property (timer_claim != 8'h00 |=>
    (((timer_shared_pins_out ^ $past(timer_func_out)) |
    (timer_shared_pins_oe ^ $past(timer_func_oe))) & $past(timer_claim))
    == 8'h00) else $error("timer does not own claimed pins");
  AST_SER: assert property (serial_func_en != 8'h00 |=>
    (((serial_shared_pins_out ^ $past(serial_func_out)) |
    (serial_shared_pins_oe ^ $past(serial_func_oe))) & $past(serial_func_en))
    == 8'h00) else $error("serial does not own enabled pins");

  // Main scenarios reached
  COV_PWM: cover property (pwm_chan_en != 4'h0);
  COV_TIM: cover property (timer_claim != 8'h00);
  COV_UP: cover property (up_rd);
endmodule

bind ppc_top ppc_top_asserts u_chk (.mclk, .rst, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hrdata, .port_a_oe, .port_b_oe, .port_e_oe,
  .modulator_shared_pins_out, .modulator_shared_pins_oe,
  .timer_shared_pins_out, .timer_shared_pins_oe, .serial_shared_pins_out,
  .serial_shared_pins_oe, .pwm_chan_en, .pwm_chan_out, .timer_claim,
  .timer_func_out, .timer_func_oe, .serial_func_en, .serial_func_out,
  .serial_func_oe, .pullup_enable, .weak_drive);

`default_nettype wire
